// ===== drive_trip_status_monitor.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Current-limit flag while demand plus offset is clamped by a limit.
// [RULE_02] Forward-bridge flag follows forward firing pulses, not conduction.
// [RULE_03] Reverse-bridge flag follows reverse firing pulses, not conduction.
// [RULE_04] At-speed when ramp settled and speed error under 1.5% of maximum.
// [RULE_05] Zero-speed flag while feedback is below the zero-speed threshold.
// [RULE_06] Alarm flag and flashing indicator while overload heads to a trip.
// [RULE_07] Field loss flagged only after no field current for 0.5 s.
// [RULE_08] Feedback loss judged only once firing angle exceeds 767.
// [RULE_09] Peak above twice rated current trips and kills firing at once.
// [RULE_10] Overload sum rises above threshold, decays below; full scale 1000.
// [RULE_11] Watchdog timeout forces shutdown and raises a watchdog trip flag.
// [RULE_12] Heatsink over 100 degrees raises the heatsink trip.
// [RULE_13] Healthy flag is one whenever not tripped.
// [RULE_14] Four-entry 8-bit trip history shifts only on a new trip.
// [RULE_15] Field-loss mask keeps detection but stops the trip; default zero.
// [RULE_16] Feedback-loss mask stops that trip; default zero.
// [RULE_17] Supply-loss mask stops supply and phase loss trips.
// [RULE_18] Motor-overtemperature mask stops the motor thermistor trip.
// [RULE_19] Heatsink mask set to one stops the heatsink trip; default zero.
// [RULE_20] External-trip bit at one trips the drive.
// [RULE_21] Co-processor code nonzero and not 255 trips; 255 acts as reset.
// [RULE_22] Current-loop-loss and armature-open masks stop their trips.
// [RULE_23] Multi-bit read-only values freeze at the trip until reset.
// [RULE_24] Any unmasked trip latches and inhibits firing until reset.
// [RULE_25] Each latched trip code becomes the newest history entry.
module drive_trip_status_monitor #(
  parameter int FIELD_DELAY_CYCLES = trip_monitor_pkg::FIELD_DELAY_CYC,
  parameter int WDOG_CYCLES = trip_monitor_pkg::WDOG_CYC_DEFAULT,
  parameter int BLINK_CYCLES = trip_monitor_pkg::ALARM_BLINK_CYC,
  parameter int OVL_W = 24
) (
  input wire logic clk, // 20 MHz control clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic drive_reset, // Drive reset pulse from keypad or serial
  input wire logic tick_ms, // One-cycle 1 ms enable from the divider
  input wire logic limit_override_clamp, // Demand clamped by limit override
  input wire logic bridge_limit_clamp, // Demand clamped by a bridge limit
  input wire logic fire_fwd_req, // Control logic fires forward bridge
  input wire logic fire_rev_req, // Control logic fires reverse bridge
  input wire logic [15:0] post_ramp_ref, // Reference after ramp
  input wire logic [15:0] pre_ramp_ref, // Reference before ramp
  input wire logic signed [15:0] speed_demand, // Final speed demand
  input wire logic signed [15:0] speed_feedback, // Measured speed
  input wire logic [15:0] max_speed, // Maximum speed setting
  input wire logic [15:0] zero_speed_thr, // Zero-speed threshold
  input wire logic field_current_present, // Field supply current sensed
  input wire logic [15:0] firing_angle, // Firing angle value
  input wire logic feedback_bad, // Feedback absent or polarity reversed
  input wire logic supply_lost, // Supply or phase loss detected
  input wire logic current_peak, // Peak above twice rated current
  input wire logic [15:0] current_feedback, // Current, full scale 1000
  input wire logic [15:0] overload_thr, // Overload threshold
  input wire logic [15:0] rise_time, // Trip time above threshold, ms
  input wire logic [15:0] fall_time, // Decay time below threshold, ms
  input wire logic wdog_kick, // Main processor watchdog restart
  input wire logic co_cpu_timeout, // Co-processor watchdog expired
  input wire logic motor_sensor_open, // Motor thermistor high resistance
  input wire logic [15:0] heatsink_temp_c, // Heatsink temperature, degrees
  input wire logic current_loop_lost, // Current loop lost
  input wire logic armature_open, // Armature circuit open
  input wire trip_monitor_pkg::trip_mask_type mask_in, // Disable bits
  input wire logic mask_we, // Write strobe for mask_in
  input wire logic external_trip_in, // External trip bit value
  input wire logic external_trip_we, // Write strobe for external bit
  input wire logic [7:0] co_cpu_code_in, // Co-processor trip byte
  input wire logic co_cpu_code_we, // Write strobe for trip byte
  input wire logic [15:0] live_value, // Multi-bit value to freeze
  output trip_monitor_pkg::status_type status, // Status flags
  output logic firing_enable, // Firing pulse permit
  output logic alarm_led, // Flashing alarm indicator
  output logic [OVL_W-1:0] overload_level, // Overload accumulator
  output logic [15:0] frozen_value, // Held on trip
  output logic [7:0] hist_newest, // Latest trip code
  output logic [7:0] hist_second, // Trip before newest
  output logic [7:0] hist_third, // Third trip back
  output logic [7:0] hist_oldest, // Oldest trip code
  output trip_monitor_pkg::trip_mask_type mask_r, // Disable bits readback
  output logic external_trip_r, // External trip bit readback
  output logic [7:0] co_cpu_code_r // Co-processor byte readback
);

  trip_monitor_pkg::run_state_type state_r;
  trip_monitor_pkg::status_type status_nxt;
  logic [31:0] field_cnt_r;
  logic [31:0] wdog_cnt_r;
  logic [31:0] blink_cnt_r;
  logic [OVL_W-1:0] ovl_r;
  logic [OVL_W-1:0] ovl_limit;
  logic ovl_trip;
  logic field_fail;
  logic fb_fail;
  logic wdog_fail;
  logic stack_hot;
  logic co_trip;
  logic co_reset;
  logic reset_req;
  logic trip_now;
  logic [7:0] trip_code;
  logic [16:0] spd_err;
  logic [31:0] tol;
  logic [7:0] hist_r [trip_monitor_pkg::HIST_DEPTH];

  assign reset_req = drive_reset | co_reset; // RULE_21
  assign co_reset = co_cpu_code_r == trip_monitor_pkg::COCPU_RESET_CODE;
  assign co_trip = (co_cpu_code_r != 8'h00) && !co_reset; // RULE_21
  assign stack_hot =
    heatsink_temp_c > trip_monitor_pkg::HEATSINK_LIMIT_C; // RULE_12
  assign field_fail = field_cnt_r >= 32'(FIELD_DELAY_CYCLES); // RULE_07
  assign fb_fail = feedback_bad &&
    (firing_angle > trip_monitor_pkg::FIRING_ANGLE_GATE); // RULE_08
  assign wdog_fail = wdog_cnt_r >= 32'(WDOG_CYCLES); // RULE_11
  // Accumulator full scale is one millisecond step per unit of trip time
  assign ovl_limit = OVL_W'(rise_time) * OVL_W'(trip_monitor_pkg::FULL_SCALE);
  assign ovl_trip = (rise_time != 16'h0000) && (ovl_r >= ovl_limit);

  // Speed error magnitude against max_speed * 15/1000
  always_comb begin
    spd_err = 17'(speed_demand) - 17'(speed_feedback);
    if (spd_err[16]) begin
      spd_err = 17'(~spd_err + 17'h00001);
    end
    tol = 32'(max_speed) * 32'(trip_monitor_pkg::SPEED_TOL_PERMIL);
  end

  // Priority picks one code when several causes coincide
  always_comb begin
    trip_now = 1'b1;
    trip_code = trip_monitor_pkg::CODE_COCPU_BASE;
    if (current_peak) begin
      trip_code = trip_monitor_pkg::CODE_PEAK; // RULE_09
    end else if (wdog_fail) begin
      trip_code = trip_monitor_pkg::CODE_WDOG; // RULE_11
    end else if (field_fail && !mask_r.field_loss) begin
      trip_code = trip_monitor_pkg::CODE_FIELD; // RULE_15
    end else if (fb_fail && !mask_r.feedback_loss) begin
      trip_code = trip_monitor_pkg::CODE_FEEDBACK; // RULE_16
    end else if (supply_lost && !mask_r.supply_loss) begin
      trip_code = trip_monitor_pkg::CODE_SUPPLY; // RULE_17
    end else if (ovl_trip) begin
      trip_code = trip_monitor_pkg::CODE_OVERLOAD; // RULE_10
    end else if (motor_sensor_open && !mask_r.motor_hot) begin
      trip_code = trip_monitor_pkg::CODE_MOTOR_HOT; // RULE_18
    end else if (stack_hot && !mask_r.stack_hot) begin
      trip_code = trip_monitor_pkg::CODE_STACK_HOT; // RULE_19
    end else if (current_loop_lost && !mask_r.current_loop_loss) begin
      trip_code = trip_monitor_pkg::CODE_CURLOOP; // RULE_22
    end else if (armature_open && !mask_r.armature_open) begin
      trip_code = trip_monitor_pkg::CODE_ARM_OPEN; // RULE_22
    end else if (external_trip_r) begin
      trip_code = trip_monitor_pkg::CODE_EXTERNAL; // RULE_20
    end else if (co_trip) begin
      trip_code = co_cpu_code_r; // RULE_21
    end else begin
      trip_now = 1'b0;
    end
  end

  // Software-written bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
      external_trip_r <= 1'b0;
      co_cpu_code_r <= 8'h00;
    end else begin
      if (mask_we) begin
        mask_r <= mask_in; // RULE_15
      end
      if (external_trip_we) begin
        external_trip_r <= external_trip_in;
      end
      if (co_cpu_code_we) begin
        co_cpu_code_r <= co_cpu_code_in;
      end else if (co_reset) begin
        // Reset request is consumed so it does not hold reset forever
        co_cpu_code_r <= 8'h00;
      end
    end
  end

  // Field loss qualification timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      field_cnt_r <= '0;
    end else if (field_current_present) begin
      field_cnt_r <= '0;
    end else if (!field_fail) begin
      field_cnt_r <= field_cnt_r + 32'h00000001; // RULE_07
    end
  end

  // Watchdog, restarted by the main processor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_cnt_r <= '0;
    end else if (wdog_kick || reset_req) begin
      wdog_cnt_r <= '0;
    end else if (!wdog_fail) begin
      wdog_cnt_r <= wdog_cnt_r + 32'h00000001; // RULE_11
    end
  end

  // I x t sum keeps cooling while tripped, or reset could never clear it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovl_r <= '0;
    end else if (tick_ms) begin
      if (current_feedback > overload_thr) begin
        if (!ovl_trip) begin
          ovl_r <= ovl_r + OVL_W'(current_feedback - overload_thr); // RULE_10
        end
      end else if (fall_time != 16'h0000) begin
        // Decay scaled so full scale drains in fall_time ms
        if (ovl_r > ovl_limit / OVL_W'(fall_time)) begin
          ovl_r <= ovl_r - ovl_limit / OVL_W'(fall_time); // RULE_10
        end else begin
          ovl_r <= '0;
        end
      end else begin
        ovl_r <= '0;
      end
    end
  end

  // Trip latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= trip_monitor_pkg::ST_RUN;
    end else begin
      case (state_r)
        trip_monitor_pkg::ST_RUN: begin
          if (trip_now) begin
            state_r <= trip_monitor_pkg::ST_TRIPPED; // RULE_24
          end
        end
        trip_monitor_pkg::ST_TRIPPED: begin
          if (reset_req && !trip_now) begin
            state_r <= trip_monitor_pkg::ST_RUN;
          end
        end
        default: begin
          state_r <= trip_monitor_pkg::ST_TRIPPED;
        end
      endcase
    end
  end

  // History shifts only on the entry into the tripped state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < trip_monitor_pkg::HIST_DEPTH; i++) begin
        hist_r[i] <= 8'h00;
      end
    end else if (state_r == trip_monitor_pkg::ST_RUN && trip_now) begin
      hist_r[0] <= trip_code; // RULE_25
      for (int i = 1; i < trip_monitor_pkg::HIST_DEPTH; i++) begin
        hist_r[i] <= hist_r[i-1]; // RULE_14
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_newest <= 8'h00;
      hist_second <= 8'h00;
      hist_third <= 8'h00;
      hist_oldest <= 8'h00;
    end else begin
      hist_newest <= hist_r[0];
      hist_second <= hist_r[1];
      hist_third <= hist_r[2];
      hist_oldest <= hist_r[3];
    end
  end

  // Multi-bit values hold while tripped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen_value <= 16'h0000;
      overload_level <= '0;
    end else if (state_r == trip_monitor_pkg::ST_RUN && !trip_now) begin
      frozen_value <= live_value; // RULE_23
      overload_level <= ovl_r; // RULE_23
    end
  end

  always_comb begin
    status_nxt = '0;
    status_nxt.current_limit_active =
      limit_override_clamp | bridge_limit_clamp; // RULE_01
    status_nxt.forward_bridge_firing = fire_fwd_req && !trip_now &&
      state_r == trip_monitor_pkg::ST_RUN; // RULE_02
    status_nxt.reverse_bridge_firing = fire_rev_req && !trip_now &&
      state_r == trip_monitor_pkg::ST_RUN; // RULE_03
    status_nxt.speed_reached = (post_ramp_ref == pre_ramp_ref) &&
      (32'(spd_err) * 32'(trip_monitor_pkg::FULL_SCALE) < tol); // RULE_04
    status_nxt.speed_below_threshold =
      (speed_feedback[15] ? 16'(-speed_feedback) : 16'(speed_feedback))
      < zero_speed_thr; // RULE_05
    status_nxt.healthy_flag = state_r == trip_monitor_pkg::ST_RUN &&
      !trip_now; // RULE_13
    status_nxt.overload_alarm_flag =
      current_feedback > overload_thr && ovl_r != '0; // RULE_06
    status_nxt.field_failed_flag = field_fail; // RULE_15
    status_nxt.feedback_missing_flag = fb_fail; // RULE_08
    status_nxt.mains_loss_flag = supply_lost;
    status_nxt.overcurrent_peak_flag = current_peak; // RULE_09
    status_nxt.i_t_overload_flag = ovl_trip;
    status_nxt.main_cpu_timeout_flag = wdog_fail; // RULE_11
    status_nxt.co_cpu_timeout_flag = co_cpu_timeout;
    status_nxt.motor_hot_flag = motor_sensor_open;
    status_nxt.stack_hot_flag = stack_hot; // RULE_12
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      firing_enable <= 1'b0;
    end else begin
      status <= status_nxt;
      // Peak and watchdog cut firing the cycle after detection
      firing_enable <= state_r == trip_monitor_pkg::ST_RUN &&
        !trip_now; // RULE_24
    end
  end

  // Alarm indicator blinks while the alarm stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_r <= '0;
      alarm_led <= 1'b0;
    end else if (!status_nxt.overload_alarm_flag) begin
      blink_cnt_r <= '0;
      alarm_led <= 1'b0;
    end else if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_r <= '0;
      alarm_led <= !alarm_led; // RULE_06
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h00000001;
    end
  end

endmodule : drive_trip_status_monitor

// ===== trip_monitor_pkg.sv
package trip_monitor_pkg;

  localparam int CLK_HZ = 20000000;
  // Field current build-up time, in milliseconds
  localparam int FIELD_DELAY_MS = 500;
  localparam int FIELD_DELAY_CYC = (CLK_HZ / 1000) * FIELD_DELAY_MS;
  localparam logic [15:0] FIRING_ANGLE_GATE = 16'h02FF; // 767
  localparam logic [15:0] FULL_SCALE = 16'h03E8; // 1000
  localparam logic [15:0] SPEED_TOL_PERMIL = 16'h000F; // 1.5% as 15/1000
  localparam logic [15:0] HEATSINK_LIMIT_C = 16'h0064; // 100 degrees
  localparam logic [7:0] COCPU_RESET_CODE = 8'hFF;
  localparam int WDOG_CYC_DEFAULT = 20000;

  // Trip codes recorded in the history
  localparam logic [7:0] CODE_FIELD = 8'h01;
  localparam logic [7:0] CODE_FEEDBACK = 8'h02;
  localparam logic [7:0] CODE_SUPPLY = 8'h03;
  localparam logic [7:0] CODE_PEAK = 8'h04;
  localparam logic [7:0] CODE_OVERLOAD = 8'h05;
  localparam logic [7:0] CODE_WDOG = 8'h06;
  localparam logic [7:0] CODE_MOTOR_HOT = 8'h07;
  localparam logic [7:0] CODE_STACK_HOT = 8'h08;
  localparam logic [7:0] CODE_EXTERNAL = 8'h09;
  localparam logic [7:0] CODE_CURLOOP = 8'h0A;
  localparam logic [7:0] CODE_ARM_OPEN = 8'h0B;
  localparam logic [7:0] CODE_COCPU_BASE = 8'h00;

  localparam int HIST_DEPTH = 4;
  localparam int ALARM_BLINK_CYC = 5000000;

  typedef struct packed {
    logic field_loss;
    logic feedback_loss;
    logic supply_loss;
    logic motor_hot;
    logic stack_hot;
    logic current_loop_loss;
    logic armature_open;
  } trip_mask_type;

  typedef struct packed {
    logic current_limit_active;
    logic forward_bridge_firing;
    logic reverse_bridge_firing;
    logic speed_reached;
    logic speed_below_threshold;
    logic healthy_flag;
    logic overload_alarm_flag;
    logic field_failed_flag;
    logic feedback_missing_flag;
    logic mains_loss_flag;
    logic overcurrent_peak_flag;
    logic i_t_overload_flag;
    logic main_cpu_timeout_flag;
    logic co_cpu_timeout_flag;
    logic motor_hot_flag;
    logic stack_hot_flag;
  } status_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_TRIPPED = 2'b01
  } run_state_type;

endpackage : trip_monitor_pkg

// ===== trip_rule_monitor.sv
`timescale 1ns/1ps
module trip_rule_monitor (
  input wire logic clk, // Control clock
  input wire logic rst, // Async reset
  input wire logic drive_reset, // Trip clear pulse
  input wire logic limit_override_clamp, // Limit override clamp
  input wire logic bridge_limit_clamp, // Bridge limit clamp
  input wire logic signed [15:0] speed_feedback, // Measured speed
  input wire logic [15:0] zero_speed_thr, // Zero-speed threshold
  input wire logic current_peak, // Overcurrent peak
  input wire logic [15:0] heatsink_temp_c, // Heatsink temperature
  input wire logic co_cpu_code_we, // Trip byte write
  input wire trip_monitor_pkg::status_type status, // Status flags
  input wire logic firing_enable, // Firing permit
  input wire logic [15:0] frozen_value, // Held value
  input wire logic [7:0] hist_newest, // History 0
  input wire logic [7:0] hist_second, // History 1
  input wire logic [7:0] hist_third, // History 2
  input wire logic [7:0] hist_oldest, // History 3
  input wire trip_monitor_pkg::trip_mask_type mask_r, // Disable bits
  input wire logic external_trip_r, // External trip bit
  input wire logic [7:0] co_cpu_code_r // Trip byte
);
  logic up_r, rel_r, rel2_r, rel, quiet;
  logic [15:0] fb_mag;
  // Any clear request in the last two cycles may still be landing
  assign rel = drive_reset | co_cpu_code_we | (co_cpu_code_r == 8'hFF);
  assign quiet = !rel && !rel_r && !rel2_r;
  assign fb_mag = speed_feedback[15] ? 16'(-speed_feedback) : speed_feedback;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_r <= 1'b0;
      rel_r <= 1'b0;
      rel2_r <= 1'b0;
    end else begin
      up_r <= up_r | status.healthy_flag;
      rel_r <= rel;
      rel2_r <= rel_r;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_limit;
    status.current_limit_active ==
      $past(limit_override_clamp | bridge_limit_clamp);
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limit flag off its cause");
  property p_zero;
    status.speed_below_threshold == $past(fb_mag < zero_speed_thr);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero speed flag wrong");
  property p_peak;
    current_peak |=> !firing_enable && status.overcurrent_peak_flag;
  endproperty
  a_peak: assert property (p_peak)
    else $error("peak did not stop firing");
  property p_health;
    status.healthy_flag == firing_enable;
  endproperty
  a_health: assert property (p_health)
    else $error("healthy flag and firing permit disagree");
  property p_latch;
    up_r && quiet && !status.healthy_flag |=> !status.healthy_flag;
  endproperty
  a_latch: assert property (p_latch)
    else $error("trip state left without reset");
  property p_hist;
    $changed({hist_newest, hist_second, hist_third, hist_oldest}) |->
      {hist_second, hist_third, hist_oldest} ==
      $past({hist_newest, hist_second, hist_third}) &&
      !$past(status.healthy_flag);
  endproperty
  a_hist: assert property (p_hist)
    else $error("history moved without a trip");
  property p_freeze;
    up_r && quiet && !status.healthy_flag && $past(!status.healthy_flag)
      |-> $stable(frozen_value);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen value moved while tripped");
  property p_stack;
    heatsink_temp_c > 16'h0064 && !mask_r.stack_hot |->
      ##[1:2] !status.healthy_flag;
  endproperty
  a_stack: assert property (p_stack)
    else $error("heatsink trip missing");
  property p_ext;
    external_trip_r |-> ##[0:2] !status.healthy_flag;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external trip missing");
  property p_cocpu;
    co_cpu_code_r != 8'h00 && co_cpu_code_r != 8'hFF |->
      ##[0:2] !status.healthy_flag;
  endproperty
  a_cocpu: assert property (p_cocpu)
    else $error("co-processor trip missing");
endmodule : trip_rule_monitor

bind drive_trip_status_monitor trip_rule_monitor trip_rule_monitor_i (.*);

// ===== drive_cpu_model.sv
`timescale 1ns/1ps
module drive_cpu_model (
  input wire logic clk, // Control clock
  input wire logic rst, // Async reset
  input wire logic kick_en, // Keep restarting the watchdog
  output logic tick_ms, // Scaled 1 ms enable
  output logic wdog_kick // Watchdog restart pulse
);
  logic [3:0] cnt_r;
  // Ticks every 8 cycles so the overload count moves within a short run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      tick_ms <= 1'b0;
      wdog_kick <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      tick_ms <= (cnt_r[2:0] == 3'h7);
      wdog_kick <= kick_en && (cnt_r == 4'hF);
    end
  end
endmodule : drive_cpu_model

// ===== drive_trip_status_monitor_bench.sv
`timescale 1ns/1ps
module drive_trip_status_monitor_bench;
  logic clk, rst, drive_reset, tick_ms, limit_override_clamp;
  logic bridge_limit_clamp, fire_fwd_req, fire_rev_req, feedback_bad;
  logic field_current_present, supply_lost, current_peak, wdog_kick;
  logic co_cpu_timeout, motor_sensor_open, current_loop_lost, mask_we;
  logic armature_open, external_trip_in, external_trip_we, kick_en;
  logic co_cpu_code_we, firing_enable, alarm_led, external_trip_r, saw;
  logic [15:0] post_ramp_ref, pre_ramp_ref, max_speed, zero_speed_thr;
  logic signed [15:0] speed_demand, speed_feedback;
  logic [15:0] firing_angle, current_feedback, overload_thr, rise_time;
  logic [15:0] fall_time, heatsink_temp_c, live_value, frozen_value, rnd;
  logic [23:0] overload_level;
  logic [7:0] co_cpu_code_in, co_cpu_code_r, hist_newest, hist_second;
  logic [7:0] hist_third, hist_oldest;
  logic [31:0] exph;
  logic [5:0] e5;
  trip_monitor_pkg::trip_mask_type mask_in, mask_r;
  trip_monitor_pkg::status_type status;
  int mismatches = 0, num_checks = 0, er, f;
  int ks[7] = '{2, 3, 4, 6, 7, 8, 9}, fl[8] = '{5, 3, 8, 7, 6, 4, 1, 0};

  drive_trip_status_monitor #(.FIELD_DELAY_CYCLES(50), .WDOG_CYCLES(40),
    .BLINK_CYCLES(4)) drive_trip_status_monitor_i (.*);
  drive_cpu_model drive_cpu_model_i (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] code_of(int k);
    logic [7:0] c [11] = '{trip_monitor_pkg::CODE_PEAK,
      trip_monitor_pkg::CODE_WDOG, trip_monitor_pkg::CODE_FIELD,
      trip_monitor_pkg::CODE_FEEDBACK, trip_monitor_pkg::CODE_SUPPLY,
      trip_monitor_pkg::CODE_OVERLOAD, trip_monitor_pkg::CODE_MOTOR_HOT,
      trip_monitor_pkg::CODE_STACK_HOT, trip_monitor_pkg::CODE_CURLOOP,
      trip_monitor_pkg::CODE_ARM_OPEN, trip_monitor_pkg::CODE_EXTERNAL};
    // Co-processor trips record their own byte
    return (k == 11) ? 8'h33 : c[k];
  endfunction : code_of

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic chk_val(string what, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string what, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic wait_health(logic v);
    int i;
    for (i = 0; i < 300 && status.healthy_flag !== v; i++) begin
      saw |= status.overload_alarm_flag & alarm_led;
      live_value = live_value + 16'h0001;
      step(1);
    end
    if (i == 300) begin
      chk_bit("healthy_flag", v, status.healthy_flag);
      print_verdict();
    end
  endtask : wait_health

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  task automatic wr_co(logic [7:0] v);
    co_cpu_code_in = v;
    pulse(co_cpu_code_we);
  endtask : wr_co

  task automatic set_cause(int k, logic v);
    case (k)
      0: current_peak = v;
      1: kick_en = !v;
      2: field_current_present = !v;
      3: feedback_bad = v;
      4: supply_lost = v;
      5: current_feedback = v ? 16'h03E8 : 16'h0000;
      6: motor_sensor_open = v;
      7: heatsink_temp_c = v ? 16'h0065 : 16'h0064;
      8: current_loop_lost = v;
      9: armature_open = v;
      10: begin
        external_trip_in = v;
        pulse(external_trip_we);
      end
      default: wr_co(v ? 8'h33 : 8'h00);
    endcase
  endtask : set_cause

  task automatic trip(int k);
    saw = 1'b0;
    set_cause(k, 1'b1);
    wait_health(1'b0);
    step(2);
    chk_val("frozen_value", live_value - 16'h0001, frozen_value);
    if (k < 8) chk_bit("cause_flag", 1'b1, status[fl[k]]);
    exph = {code_of(k), exph[31:8]};
    chk_val("hist_upper", exph[31:16], {hist_newest, hist_second});
    chk_val("hist_lower", exph[15:0], {hist_third, hist_oldest});
    chk_bit("firing_enable", 1'b0, firing_enable);
    if (k == 5) chk_bit("alarm", 1'b1, saw);
    if (k == 5) chk_val("overload", 16'h01F4, overload_level[15:0]);
    pulse(drive_reset);
    step(3);
    chk_bit("healthy_flag", 1'b0, status.healthy_flag);
    if (k == 11) wr_co(8'hFF);
    else begin
      set_cause(k, 1'b0);
      step(20);
      pulse(drive_reset);
    end
    wait_health(1'b1);
    chk_bit("firing_enable", 1'b1, firing_enable);
  endtask : trip

  initial begin
    rst = 1'b1;
    {drive_reset, limit_override_clamp, bridge_limit_clamp, fire_fwd_req,
      fire_rev_req, feedback_bad, supply_lost, current_peak, co_cpu_timeout,
      motor_sensor_open, current_loop_lost, armature_open, mask_we,
      external_trip_in, external_trip_we, co_cpu_code_we} = '0;
    {post_ramp_ref, pre_ramp_ref, speed_demand, speed_feedback, max_speed,
      zero_speed_thr, current_feedback, live_value, co_cpu_code_in} = '0;
    field_current_present = 1'b1;
    kick_en = 1'b1;
    mask_in = '0;
    firing_angle = 16'h02FF;
    overload_thr = 16'h01F4;
    rise_time = 16'h0001;
    fall_time = 16'h0001;
    heatsink_temp_c = 16'h0064;
    exph = '0;
    rnd = 16'h0038;
    repeat (16) @(posedge clk);
    #2 rst = 1'b0;
    step(2);
    chk_bit("healthy_flag", 1'b1, status.healthy_flag);
    chk_val("mask_r", 16'h0000, {9'h000, mask_r});
    chk_bit("external_trip_r", 1'b0, external_trip_r);
    chk_val("hist_upper", 16'h0000, {hist_newest, hist_second});
    for (int n = 0; n < 200; n++) begin
      rnd = lfsr(rnd);
      {limit_override_clamp, bridge_limit_clamp} = rnd[1:0];
      {fire_fwd_req, fire_rev_req} = rnd[3:2];
      co_cpu_timeout = rnd[6];
      speed_demand = rnd;
      post_ramp_ref = rnd;
      rnd = lfsr(rnd);
      pre_ramp_ref = rnd[5] ? post_ramp_ref : rnd;
      speed_feedback = rnd[4] ? speed_demand + 16'(rnd[3:0]) : rnd;
      max_speed = {1'b0, rnd[15:1]};
      rnd = lfsr(rnd);
      zero_speed_thr = rnd;
      live_value = rnd;
      er = int'(speed_demand) - int'(speed_feedback);
      er = (er < 0) ? -er : er;
      f = int'(speed_feedback);
      f = (f < 0) ? -f : f;
      e5 = {limit_override_clamp | bridge_limit_clamp, fire_fwd_req,
        fire_rev_req, post_ramp_ref == pre_ramp_ref &&
        er * 1000 < int'(max_speed) * 15, f < int'(zero_speed_thr),
        co_cpu_timeout};
      step(1);
      chk_val("status_bits", {10'h000, e5}, {10'h000, status[15:11],
        status[2]});
    end
    // Boundary values must not trip: angle 767 and heatsink at 100
    feedback_bad = 1'b1;
    step(20);
    chk_bit("healthy_flag", 1'b1, status.healthy_flag);
    feedback_bad = 1'b0;
    firing_angle = 16'h0300;
    for (int k = 0; k < 12; k++) trip(k);
    for (int b = 0; b < 7; b++) begin
      mask_in = 7'h40 >> b;
      pulse(mask_we);
      step(1);
      chk_val("mask_r", {9'h000, mask_in}, {9'h000, mask_r});
      set_cause(ks[b], 1'b1);
      step(60);
      chk_bit("healthy_flag", 1'b1, status.healthy_flag);
      if (b == 0) chk_bit("field_failed", 1'b1, status.field_failed_flag);
      set_cause(ks[b], 1'b0);
      step(2);
      mask_in = '0;
      pulse(mask_we);
    end
    print_verdict();
  end
endmodule : drive_trip_status_monitor_bench
